// ==== hdl/fecc_status.sv ====
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fecc_status #(
  parameter int UAW = fecc_pkg::UADDR_W
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          rd_start,
  input  wire logic                          unit_valid,
  input  wire logic [UAW-1:0]                unit_addr,
  input  wire logic [fecc_pkg::DATA_W-1:0]   unit_data,
  input  wire logic [fecc_pkg::SYN_W-1:0]    unit_syn,
  input  wire logic                          unit_ecc_dis,
  output logic                               rd_valid,
  output logic      [fecc_pkg::DATA_W-1:0]   rd_data,
  output logic                               rd_dbl,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [31:0]                   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  // ----------------------------------------------------------------
  // Decode of the unit being read
  // ----------------------------------------------------------------
  logic [1:0]                  ctrl;
  logic [fecc_pkg::DATA_W-1:0] dec_data;
  logic                        dec_dcorr;
  logic                        dec_scorr;
  logic                        dec_dbl;
  logic                        ev;
  logic                        ev_sgl;
  logic                        ev_dbl;

  fecc_decode u_dec (
    .data_in   (unit_data),
    .syn_in    (unit_syn),
    .dbl_en    (ctrl[fecc_pkg::CTRL_DBL_EN]),
    .data_out  (dec_data),
    .data_corr (dec_dcorr),
    .syn_corr  (dec_scorr),
    .dbl_err   (dec_dbl)
  );

  assign ev     = unit_valid && !unit_ecc_dis;
  assign ev_sgl = ev && (dec_dcorr || dec_scorr);
  assign ev_dbl = ev && dec_dbl;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_do;
  logic        wr_ok;
  logic [UAW-1:0] sel;
  logic        cmd_clear;
  logic        cmd_exit;
  logic        ovl_act;

  assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = aw_addr == fecc_pkg::OFS_CTRL || aw_addr == fecc_pkg::OFS_CMD
              || aw_addr == fecc_pkg::OFS_SEL;
  assign cmd_clear = wr_do && aw_addr == fecc_pkg::OFS_CMD && w_strb[0]
                  && w_data[fecc_pkg::CMD_CLEAR];
  assign cmd_exit = wr_do && aw_addr == fecc_pkg::OFS_CMD && w_strb[0]
                 && w_data[fecc_pkg::CMD_OVL_EXIT] && ovl_act;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fecc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? fecc_pkg::RESP_OKAY : fecc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control, selection and overlay state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= fecc_pkg::CTRL_RESET;
    end else if (wr_do && aw_addr == fecc_pkg::OFS_CTRL && w_strb[0]) begin
      ctrl <= w_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel <= '0;
    end else if (wr_do && aw_addr == fecc_pkg::OFS_SEL) begin
      for (int i = 0; i < UAW; i++) begin
        if (w_strb[i / 8]) sel[i] <= w_data[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovl_act <= 1'b0;
    end else if (cmd_exit) begin
      ovl_act <= 1'b0;
    end else if (wr_do && aw_addr == fecc_pkg::OFS_CMD && w_strb[0]
                 && w_data[fecc_pkg::CMD_OVL_ENT]) begin
      ovl_act <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Global sticky flags, set wins over clear
  // ----------------------------------------------------------------
  logic g_sgl;
  logic g_dbl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g_sgl <= 1'b0;
      g_dbl <= 1'b0;
    end else begin
      g_sgl <= ev_sgl || (g_sgl && !(cmd_clear || cmd_exit));
      g_dbl <= ev_dbl || (g_dbl && !(cmd_clear || cmd_exit));
    end
  end

  // ----------------------------------------------------------------
  // Per-unit status: last unit read and selected unit
  // ----------------------------------------------------------------
  logic [4:0] ust;
  logic [4:0] sst;
  logic [4:0] cur;

  assign cur = {1'b1, unit_ecc_dis, ev && dec_dbl, ev && dec_scorr, ev && dec_dcorr};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ust <= 5'h00;
      sst <= 5'h00;
    end else if (unit_valid) begin
      ust <= cur;
      if (unit_addr == sel) sst <= cur;
    end
  end

  // ----------------------------------------------------------------
  // Address trap
  // ----------------------------------------------------------------
  logic [UAW-1:0] trap_addr;
  logic           trap_val;
  logic           trap_held;
  logic           trap_cap;

  assign trap_cap = ev_dbl || (ev_sgl && !ctrl[fecc_pkg::CTRL_REDUCED]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_addr <= '0;
      trap_val  <= 1'b0;
      trap_held <= 1'b0;
    end else if (trap_cap && (rd_start || !trap_held)) begin
      trap_addr <= unit_addr;
      trap_val  <= 1'b1;
      trap_held <= 1'b1;
    end else if (rd_start) begin
      trap_held <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data path to the host
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
      rd_dbl   <= 1'b0;
    end else begin
      rd_valid <= unit_valid;
      rd_dbl   <= ev_dbl;
      if (unit_valid) rd_data <= unit_ecc_dis ? unit_data : dec_data;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  logic        rok;

  always_comb begin
    rmux = 32'h0000_0000;
    rok  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      fecc_pkg::OFS_CTRL:  rmux[1:0] = ctrl;
      fecc_pkg::OFS_CMD:   rmux = 32'h0000_0000;
      fecc_pkg::OFS_GSTAT: rmux[2:0] = {ovl_act, g_dbl, g_sgl};
      fecc_pkg::OFS_USTAT: rmux[4:0] = ust;
      fecc_pkg::OFS_SEL:   rmux[UAW-1:0] = sel;
      fecc_pkg::OFS_SSTAT: rmux[4:0] = sst;
      fecc_pkg::OFS_TRAP: begin
        rmux[UAW-1:0] = trap_addr;
        rmux[fecc_pkg::TRAP_VALID] = trap_val;
      end
      default: rok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= fecc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rmux;
      s_axi_rresp   <= rok ? fecc_pkg::RESP_OKAY : fecc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_dbl_flag;
    @(posedge aclk) disable iff (!aresetn) ev_dbl |=> g_dbl && rd_dbl;
  endproperty
  a_dbl_flag: assert property (p_dbl_flag) else $error("double error not flagged");

  property p_sgl_flag;
    @(posedge aclk) disable iff (!aresetn) ev_sgl |=> g_sgl;
  endproperty
  a_sgl_flag: assert property (p_sgl_flag) else $error("single error not flagged");

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
      g_sgl && !cmd_clear && !cmd_exit |=> g_sgl;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      cmd_clear && !ev |=> !g_sgl && !g_dbl;
  endproperty
  a_clear: assert property (p_clear) else $error("clear command ignored");

  property p_exit;
    @(posedge aclk) disable iff (!aresetn)
      cmd_exit && !ev |=> !g_sgl && !g_dbl && !ovl_act;
  endproperty
  a_exit: assert property (p_exit) else $error("overlay exit did not clear");

  property p_sel_indep;
    @(posedge aclk) disable iff (!aresetn)
      !ev && !cmd_clear && !cmd_exit |=> $stable(g_sgl) && $stable(g_dbl);
  endproperty
  a_sel_indep: assert property (p_sel_indep) else $error("flags moved without event");

  property p_first;
    @(posedge aclk) disable iff (!aresetn)
      trap_held && !rd_start |=> $stable(trap_addr);
  endproperty
  a_first: assert property (p_first) else $error("trap overwritten in same read");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
      trap_cap && !trap_held |=> trap_val && trap_addr == $past(unit_addr);
  endproperty
  a_capture: assert property (p_capture) else $error("trap missed error address");

  property p_reduced;
    @(posedge aclk) disable iff (!aresetn)
      ctrl[fecc_pkg::CTRL_REDUCED] && !ev_dbl ##1 !rd_start |-> $stable(trap_addr);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced trap took single error");

  property p_disabled;
    @(posedge aclk) disable iff (!aresetn)
      unit_valid && unit_ecc_dis |=> !rd_dbl && rd_data == $past(unit_data);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled unit was checked");
endmodule

// ==== hdl/fecc_pkg.sv ====
package fecc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int UNIT_BYTES = 16;
  localparam int DATA_W     = UNIT_BYTES * 8;
  localparam int CHK_W      = 8;
  localparam int SYN_W      = CHK_W + 1;
  localparam int UADDR_W    = 22;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_GSTAT = 8'h08;
  localparam logic [7:0] OFS_USTAT = 8'h0C;
  localparam logic [7:0] OFS_SEL   = 8'h10;
  localparam logic [7:0] OFS_SSTAT = 8'h14;
  localparam logic [7:0] OFS_TRAP  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DBL_EN  = 0;
  localparam int CTRL_REDUCED = 1;
  localparam int CMD_CLEAR    = 0;
  localparam int CMD_OVL_EXIT = 1;
  localparam int CMD_OVL_ENT  = 2;
  localparam int GST_SGL      = 0;
  localparam int GST_DBL      = 1;
  localparam int GST_OVL      = 2;
  localparam int UST_DCORR    = 0;
  localparam int UST_SCORR    = 1;
  localparam int UST_DBL      = 2;
  localparam int UST_DIS      = 3;
  localparam int UST_VALID    = 4;
  localparam int TRAP_VALID   = 31;

  // ----------------------------------------------------------------
  // Reset values and responses
  // ----------------------------------------------------------------
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/fecc_decode.sv ====
`timescale 1ns/1ps
module fecc_decode #(
  parameter int DW = fecc_pkg::DATA_W,
  parameter int CW = fecc_pkg::CHK_W
) (
  input  wire logic [DW-1:0] data_in,
  input  wire logic [CW:0]   syn_in,
  input  wire logic          dbl_en,
  output logic      [DW-1:0] data_out,
  output logic               data_corr,
  output logic               syn_corr,
  output logic               dbl_err
);
  // ----------------------------------------------------------------
  // Hamming check over data bits placed at non-power-of-two positions
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] calc(input logic [DW-1:0] d);
    logic [CW-1:0] c;
    int            k;
    c = '0;
    k = 0;
    for (int p = 3; p <= DW + CW; p++) begin
      if ((p & (p - 1)) != 0 && k < DW) begin
        if (d[k]) c = c ^ CW'(p);
        k++;
      end
    end
    return c;
  endfunction

  logic [CW-1:0] syndrome;
  logic          par_err;
  logic          onehot;
  logic [DW-1:0] flip;
  int            k;

  always_comb begin
    syndrome = calc(data_in) ^ syn_in[CW-1:0];
    par_err  = (^data_in) ^ (^syn_in);
    onehot   = (syndrome != '0) && ((syndrome & (syndrome - 1'b1)) == '0);
    flip     = '0;
    k        = 0;
    for (int p = 3; p <= DW + CW; p++) begin
      if ((p & (p - 1)) != 0 && k < DW) begin
        if (syndrome == CW'(p)) flip[k] = 1'b1;
        k++;
      end
    end
    // One data bit plus one syndrome bit leaves parity even: double
    if (dbl_en) begin
      dbl_err   = (syndrome != '0 && !par_err) || (par_err && !onehot
                  && syndrome != '0 && flip == '0);
      syn_corr  = par_err && (syndrome == '0 || onehot);
      data_corr = par_err && flip != '0;
    end else begin
      dbl_err   = 1'b0;
      syn_corr  = onehot;
      data_corr = flip != '0;
    end
    data_out = data_corr ? (data_in ^ flip) : data_in;
  end
endmodule

// ==== tb/fecc_array_model.sv ====
`timescale 1ns/1ps
// --------------------
// Array side model
// --------------------
module fecc_array_model (
  input  wire logic                          aclk,
  output logic                               rd_start,
  output logic                               unit_valid,
  output logic [fecc_pkg::UADDR_W-1:0]       unit_addr,
  output logic [fecc_pkg::DATA_W-1:0]        unit_data,
  output logic [fecc_pkg::SYN_W-1:0]         unit_syn,
  output logic                               unit_ecc_dis
);
  initial begin
    rd_start     = 1'b0;
    unit_valid   = 1'b0;
    unit_addr    = '0;
    unit_data    = '0;
    unit_syn     = '0;
    unit_ecc_dis = 1'b0;
  end

  // Check bits are the XOR of data positions, top bit is overall parity
  function automatic logic [8:0] enc(input logic [127:0] d);
    logic [7:0] c;
    int         p;
    c = 8'h00;
    p = 3;
    for (int k = 0; k < 128; k++) begin
      while ((p & (p - 1)) == 0) begin
        p++;
      end
      if (d[k]) begin
        c ^= p[7:0];
      end
      p++;
    end
    return {^{d, c}, c};
  endfunction

  // One unit per call; flips model stored faults; more keeps the burst going
  task automatic send(input logic [21:0] a, input logic [127:0] d, input logic [127:0] fd,
                      input logic [8:0] fs, input logic dis, input logic st, input logic more);
    rd_start     <= st;
    unit_valid   <= 1'b1;
    unit_addr    <= a;
    unit_data    <= d ^ fd;
    unit_syn     <= enc(d) ^ fs;
    unit_ecc_dis <= dis;
    @(posedge aclk);
    if (!more) begin
      rd_start   <= 1'b0;
      unit_valid <= 1'b0;
      unit_data  <= ~(d ^ fd);
      unit_syn   <= ~(enc(d) ^ fs);
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam logic [1:0] OK = fecc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = fecc_pkg::RESP_SLVERR;
  logic         aclk, aresetn, rd_start, unit_valid, unit_ecc_dis, rd_valid, rd_dbl;
  logic [21:0]  unit_addr, a;
  logic [127:0] unit_data, rd_data, d;
  logic [8:0]   unit_syn;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [129:0] uq[$], ue;
  logic [33:0]  bq[$], be;
  int           mismatches, n_compared, cycles;
  integer       seed = 32'h3a50;

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  fecc_array_model u_arr (.aclk, .rd_start, .unit_valid, .unit_addr, .unit_data, .unit_syn,
                          .unit_ecc_dis);
  fecc_status u_dut (.aclk, .aresetn, .rd_start, .unit_valid, .unit_addr, .unit_data, .unit_syn,
                     .unit_ecc_dis, .rd_valid, .rd_data, .rd_dbl, .s_axi_awaddr, .s_axi_awvalid,
                     .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
                     .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
                     .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // --------------------
  // Result monitor
  // --------------------
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
    if (rd_valid) begin
      ue = uq.pop_front();
      `CHK(rd_dbl, ue[128])
      if (ue[129]) `CHK(rd_data, ue[127:0])
    end
    if (s_axi_rvalid && s_axi_rready) begin
      be = bq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, be)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      be = bq.pop_front();
      `CHK(s_axi_bresp, be[33:32])
    end
  end

  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // --------------------
  // Drivers
  // --------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] dv, input logic [1:0] r);
    logic aw, w;
    bq.push_back({r, 32'h0});
    aw = 1'b0;
    w  = 1'b0;
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] dv, input logic [1:0] r);
    bq.push_back({r, dv});
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic un(input logic [21:0] ua, input logic [127:0] fd, input logic [8:0] fs,
                    input logic dis, input logic st, input logic more);
    logic dbl;
    dbl = !dis && (fd != 0) && (fs != 0);
    uq.push_back({!dbl, dbl, dis ? d ^ fd : d});
    u_arr.send(ua, d, fd, fs, dis, st, more);
  endtask

  function automatic logic [127:0] fb();
    return 128'h1 << ($unsigned($random(seed)) % 128);
  endfunction

  function automatic logic [31:0] tp(input logic [21:0] ua);
    return {1'b1, 9'h000, ua};
  endfunction

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    aresetn       = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(fecc_pkg::OFS_GSTAT, 32'h0, OK);
    rd(fecc_pkg::OFS_TRAP, 32'h0, OK);
    rd(fecc_pkg::OFS_CTRL, 32'h1, OK);
    a = 22'($random(seed));
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    un(a, '0, 9'h000, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_USTAT, 32'h10, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h0, OK);
    un(a, fb(), 9'h000, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_USTAT, 32'h11, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h1, OK);
    rd(fecc_pkg::OFS_TRAP, tp(a), OK);
    un(a + 22'd1, '0, 9'h001 << ($unsigned($random(seed)) % 8), 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_USTAT, 32'h12, OK);
    un(a, fb(), 9'h004, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_USTAT, 32'h14, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h3, OK);
    un(a + 22'd2, '0, 9'h000, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_GSTAT, 32'h3, OK);
    wr(fecc_pkg::OFS_CMD, 32'h1, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h0, OK);
    un(a + 22'd5, '0, 9'h000, 1'b0, 1'b1, 1'b1);
    un(a + 22'd6, fb(), 9'h000, 1'b0, 1'b0, 1'b1);
    un(a + 22'd7, fb(), 9'h002, 1'b0, 1'b0, 1'b0);
    rd(fecc_pkg::OFS_TRAP, tp(a + 22'd6), OK);
    wr(fecc_pkg::OFS_CMD, 32'h1, OK);
    un(a + 22'd9, fb(), 9'h003, 1'b1, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_USTAT, 32'h18, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h0, OK);
    rd(fecc_pkg::OFS_TRAP, tp(a + 22'd6), OK);
    wr(fecc_pkg::OFS_SEL, {10'h0, a + 22'd20}, OK);
    rd(fecc_pkg::OFS_SEL, {10'h0, a + 22'd20}, OK);
    un(a + 22'd20, fb(), 9'h000, 1'b0, 1'b1, 1'b1);
    un(a + 22'd21, '0, 9'h000, 1'b1, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_SSTAT, 32'h11, OK);
    wr(fecc_pkg::OFS_SEL, {10'h0, a + 22'd21}, OK);
    un(a + 22'd21, '0, 9'h000, 1'b1, 1'b1, 1'b1);
    un(a + 22'd22, '0, 9'h000, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_SSTAT, 32'h18, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h1, OK);
    wr(fecc_pkg::OFS_CMD, 32'h2, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h1, OK);
    wr(fecc_pkg::OFS_CMD, 32'h4, OK);
    un(a + 22'd23, fb(), 9'h080, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_GSTAT, 32'h7, OK);
    wr(fecc_pkg::OFS_CMD, 32'h2, OK);
    rd(fecc_pkg::OFS_GSTAT, 32'h0, OK);
    wr(fecc_pkg::OFS_CTRL, 32'h3, OK);
    rd(fecc_pkg::OFS_CTRL, 32'h3, OK);
    un(a + 22'd30, fb(), 9'h000, 1'b0, 1'b1, 1'b1);
    un(a + 22'd31, fb(), 9'h010, 1'b0, 1'b0, 1'b0);
    rd(fecc_pkg::OFS_TRAP, tp(a + 22'd31), OK);
    wr(8'h1C, 32'h0, ER);
    rd(8'hFC, 32'h0, ER);
    // Double detection off: parity bit ignored, data bit still corrected
    wr(fecc_pkg::OFS_CTRL, 32'h0, OK);
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    uq.push_back({1'b1, 1'b0, d});
    u_arr.send(a + 22'd40, d, fb(), 9'h100, 1'b0, 1'b1, 1'b0);
    rd(fecc_pkg::OFS_USTAT, 32'h11, OK);
    for (int i = 0; i < 8; i++) begin
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      un(22'($random(seed)), (i % 2) ? fb() : '0, 9'h000, 1'b0, i == 0, i != 7);
    end
    rd(fecc_pkg::OFS_GSTAT, 32'h3, OK);
    `CHK(uq.size(), 0)
    `CHK(bq.size(), 0)
    report_and_stop();
  end
endmodule
